// [hw/gsc_ctrl_end.sv]
// gsc_ctrl_end: memory controller end, driven by software registers.
// assumes a plain register port; read data one cycle after the strobe.
`default_nettype none

module gsc_ctrl_end
    import gsc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // link
    gsc_if.ctrl              bus
);
    logic [9:0]  addr_reg;
    logic [31:0] wdata_reg;
    logic [4:0]  ctrl_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  banks;
    logic        refused;
    logic        rd_new;

    logic [3:0]  code;
    logic        is_rw;
    logic        bad;
    logic        cmd_wr;

    assign cmd_wr = reg_wr && reg_addr == GSC_REG_CMD;
    assign code   = reg_wdata[3:0];
    assign is_rw  = code == GSC_CMD_READ || code == GSC_CMD_WRITE || code == GSC_CMD_BLOCK_WR;
    // refuse access to a closed bank
    assign bad    = cmd_wr && is_rw && !banks[addr_reg[9]];

    // ---------------------------------------------------------------
    // command pins
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bus.cs_n  <= 1'b1;
            {bus.ras_n, bus.cas_n, bus.we_n, bus.special_function_select} <= GSC_CMD_NOP;
            bus.ba    <= 1'b0;
            bus.addr  <= '0;
            bus.ctl_dq_oe  <= 1'b0;
            bus.ctl_dq_out <= '0;
        end
        else
        begin
            bus.cs_n <= !(cmd_wr && !bad);
            {bus.ras_n, bus.cas_n, bus.we_n, bus.special_function_select}
                <= (cmd_wr && !bad) ? code : GSC_CMD_NOP;
            bus.ba   <= addr_reg[9];
            bus.addr <= addr_reg[8:0];
            // a data write drives one beat the next cycle for bursts
            bus.ctl_dq_oe  <= (cmd_wr && !bad && reg_wdata[GSC_CMD_DRIVE_BIT])
                           || (reg_wr && reg_addr == GSC_REG_WDATA);
            bus.ctl_dq_out <= (reg_wr && reg_addr == GSC_REG_WDATA) ? reg_wdata : wdata_reg;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            addr_reg  <= 10'h000;
            wdata_reg <= 32'h0000_0000;
            ctrl_reg  <= GSC_CTRL_RESET;
        end
        else if (reg_wr)
        begin
            if (reg_addr == GSC_REG_ADDR)
                addr_reg <= reg_wdata[9:0];
            if (reg_addr == GSC_REG_WDATA)
                wdata_reg <= reg_wdata;
            // clock gate may drop only with both banks closed
            if (reg_addr == GSC_REG_CTRL)
                ctrl_reg <= {reg_wdata[GSC_CTRL_CKE_BIT] || banks != 2'b00, reg_wdata[3:0]};
        end
    end

    assign bus.cke             = ctrl_reg[GSC_CTRL_CKE_BIT];
    assign bus.byte_lane_masks = ctrl_reg[3:0];

    // mirror of the device bank state as set by active and precharge; autoprecharge is not tracked
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            banks <= 2'b00;
        else if (!bus.cs_n && bus.cke)
        begin
            if ({bus.ras_n, bus.cas_n, bus.we_n, bus.special_function_select} == GSC_CMD_ACTIVE)
                banks[bus.ba] <= 1'b1;
            else if ({bus.ras_n, bus.cas_n, bus.we_n, bus.special_function_select} == GSC_CMD_PRECHARGE)
            begin
                if (bus.addr[GSC_AP_BIT])
                    banks <= 2'b00;
                else
                    banks[bus.ba] <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // capture and sticky status, set wins over clear
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_reg <= 32'h0000_0000;
            rd_new    <= 1'b0;
            refused   <= 1'b0;
        end
        else
        begin
            if (|bus.dev_dq_oe)
                rdata_reg <= bus.data_lines;
            rd_new  <= (|bus.dev_dq_oe) || (rd_new && !(reg_rd && reg_addr == GSC_REG_RDATA));
            refused <= bad || (refused && !(reg_wr && reg_addr == GSC_REG_STATUS
                               && reg_wdata[GSC_ST_REFUSE_BIT]));
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                GSC_REG_ADDR:   reg_rdata <= {22'h000000, addr_reg};
                GSC_REG_WDATA:  reg_rdata <= wdata_reg;
                GSC_REG_CTRL:   reg_rdata <= {27'h0000000, ctrl_reg};
                GSC_REG_RDATA:  reg_rdata <= rdata_reg;
                GSC_REG_STATUS: reg_rdata <= {28'h0000000, rd_new, refused, banks};
                default:        reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end
endmodule

`default_nettype wire

// [hw/gsc_if.sv]
// gsc_if: pins between controller and memory.
// assumes both ends share clk; data_lines resolved here from enables.
`default_nettype none

interface gsc_if
    import gsc_pkg::*;
(
    input wire logic clk
);
    logic                  cke;
    logic                  cs_n;
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic                  special_function_select;
    logic                  ba;
    logic [GSC_ROW_W-1:0]  addr;
    logic [GSC_LANES-1:0]  byte_lane_masks;
    logic [GSC_DATA_W-1:0] ctl_dq_out;
    logic                  ctl_dq_oe;
    logic [GSC_DATA_W-1:0] dev_dq_out;
    logic [GSC_LANES-1:0]  dev_dq_oe;
    logic [GSC_DATA_W-1:0] data_lines;

    // undriven lanes read as zero
    always_comb
    begin
        for (int l = 0; l < GSC_LANES; l++)
        begin
            if (dev_dq_oe[l])
                data_lines[l*8 +: 8] = dev_dq_out[l*8 +: 8];
            else if (ctl_dq_oe)
                data_lines[l*8 +: 8] = ctl_dq_out[l*8 +: 8];
            else
                data_lines[l*8 +: 8] = 8'h00;
        end
    end

    modport ctrl
    (
        output cke, cs_n, ras_n, cas_n, we_n, special_function_select,
        output ba, addr, byte_lane_masks, ctl_dq_out, ctl_dq_oe,
        input  data_lines, dev_dq_oe
    );
    modport mem
    (
        input  cke, cs_n, ras_n, cas_n, we_n, special_function_select,
        input  ba, addr, byte_lane_masks, data_lines,
        output dev_dq_out, dev_dq_oe
    );
endinterface

`default_nettype wire

// [hw/gsc_mem_end.sv]
// gsc_mem_end: two-bank x32 graphics sdram, command and data side.
// assumes a controller on the same clk drives the pins of gsc_if.mem.
//
// Overview of operation
// - sample every input on rising clk only
// - each edge advances burst column, output registers
// - clock gate low stops clock; idle enters power-down
// - in power-down gate seen without clock gating
// - chip select high masks every command
// - command decoded from strobes, special select, select
// - byte mask is per cycle; blocks write data
// - read byte mask acts two clocks later
// - mask n covers data bits 8n to 8n+7
// - bank select picks bank of bank commands
// - bank select is tenth mode op-code bit
// - active captures nine row address bits
// - column bits 0-7; bit eight requests autoprecharge
// - precharge with bit eight high closes both
// - 131,072 words per bank, row plus column
// - mode loads store op-code from address
// - block write: data lines are column enables
// - every byte lane maskable on reads, writes
// - bursts 1,2,4,8 or page, with terminate
// - bank is 512 rows by 256 columns
// - block write fills eight columns, byte masked
//
// Chosen here: the strobed register port and the address map.
`default_nettype none

module gsc_mem_end
    import gsc_pkg::*;
#(
    parameter int ROW_W = GSC_ROW_W,
    parameter int COL_W = GSC_COL_W
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // link
    gsc_if.mem              bus,
    // status
    output logic            power_down,
    output logic            self_refresh,
    output logic [1:0]      bank_open,
    output logic [9:0]      mode_reg,
    output logic [9:0]      special_mode_reg
);
    localparam int IDX_W = 1 + ROW_W + COL_W;

    // ---------------------------------------------------------------
    // storage and per-bank state
    // ---------------------------------------------------------------
    logic [GSC_DATA_W-1:0] mem [0:(1<<IDX_W)-1];
    logic [ROW_W-1:0]      open_row [0:GSC_BANKS-1];
    logic [GSC_DATA_W-1:0] color;
    gsc_state_t            state;

    logic                  bst_on;
    logic                  bst_wr;
    logic                  bst_ap;
    logic                  bst_full;
    logic                  bst_bank;
    logic [COL_W-1:0]      bst_col;
    logic [COL_W-1:0]      bst_mask;
    logic [8:0]            bst_left;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    logic [3:0]       cmd;
    logic             take;
    logic [8:0]       bl_len;
    logic             acc_en;
    logic             acc_wr;
    logic             acc_blk;
    logic             acc_bank;
    logic [COL_W-1:0] acc_col;
    logic             start;
    logic             stop;

    assign cmd  = {bus.ras_n, bus.cas_n, bus.we_n, bus.special_function_select};
    assign take = (state == GSC_ST_RUN) && bus.cke && !bus.cs_n;

    // burst length from the mode register
    always_comb
    begin
        case (mode_reg[GSC_BL_LSB +: 3])
            3'h0:    bl_len = 9'h001;
            3'h1:    bl_len = 9'h002;
            3'h2:    bl_len = 9'h004;
            3'h3:    bl_len = 9'h008;
            default: bl_len = 9'h100;
        endcase
    end

    assign start = take && (cmd == GSC_CMD_READ || cmd == GSC_CMD_WRITE || cmd == GSC_CMD_BLOCK_WR);
    // a precharge of the bursting bank or a terminate ends the burst
    assign stop = take && (cmd == GSC_CMD_BURST_END
                  || (cmd == GSC_CMD_PRECHARGE && (bus.addr[GSC_AP_BIT] || bus.ba == bst_bank)));

    always_comb
    begin
        acc_en   = 1'b0;
        acc_wr   = 1'b0;
        acc_blk  = 1'b0;
        acc_bank = bus.ba;
        acc_col  = bus.addr[COL_W-1:0];
        if (start)
        begin
            acc_en  = 1'b1;
            acc_wr  = (cmd != GSC_CMD_READ);
            acc_blk = (cmd == GSC_CMD_BLOCK_WR);
        end
        else if (bst_on && bus.cke && !stop)
        begin
            acc_en   = 1'b1;
            acc_wr   = bst_wr;
            acc_bank = bst_bank;
            acc_col  = bst_col;
        end
    end

    // ---------------------------------------------------------------
    // power state
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state <= GSC_ST_RUN;
        else
        begin
            case (state)
                GSC_ST_RUN:
                    if (!bus.cke && bank_open == 2'b00 && !bst_on)
                    begin
                        if (!bus.cs_n && cmd == GSC_CMD_REFRESH)
                            state <= GSC_ST_SREF;
                        else
                            state <= GSC_ST_PDN;
                    end
                // exit on gate alone; commands in that cycle are dropped
                GSC_ST_PDN, GSC_ST_SREF:
                    if (bus.cke)
                        state <= GSC_ST_RUN;
                default:
                    state <= GSC_ST_RUN;
            endcase
        end
    end

    assign power_down   = (state == GSC_ST_PDN);
    assign self_refresh = (state == GSC_ST_SREF);

    // ---------------------------------------------------------------
    // banks and mode registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bank_open        <= 2'b00;
            mode_reg         <= GSC_MODE_RESET;
            special_mode_reg <= GSC_MODE_RESET;
        end
        else if (take)
        begin
            case (cmd)
                GSC_CMD_ACTIVE:
                    bank_open[bus.ba] <= 1'b1;
                GSC_CMD_PRECHARGE:
                    if (bus.addr[GSC_AP_BIT])
                        bank_open <= 2'b00;
                    else
                        bank_open[bus.ba] <= 1'b0;
                GSC_CMD_LOAD_MODE:
                    mode_reg <= {bus.ba, bus.addr};
                GSC_CMD_LOAD_SPM:
                    special_mode_reg <= {bus.ba, bus.addr};
                default:
                    if (start && bus.addr[GSC_AP_BIT] && bl_len == 9'h001)
                        bank_open[bus.ba] <= 1'b0;
            endcase
        end
        else if (bst_on && bus.cke && bst_ap && bst_left == 9'h001)
            bank_open[bst_bank] <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (take && cmd == GSC_CMD_ACTIVE)
            open_row[bus.ba] <= bus.addr;
        if (take && cmd == GSC_CMD_LOAD_SPM && bus.addr[GSC_SPM_COLOR_BIT])
            color <= bus.data_lines;
    end

    // ---------------------------------------------------------------
    // burst sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bst_on   <= 1'b0;
            bst_wr   <= 1'b0;
            bst_ap   <= 1'b0;
            bst_full <= 1'b0;
            bst_bank <= 1'b0;
            bst_col  <= '0;
            bst_mask <= '0;
            bst_left <= 9'h000;
        end
        else if (start)
        begin
            bst_on   <= (cmd != GSC_CMD_BLOCK_WR) && (bl_len != 9'h001);
            bst_wr   <= (cmd == GSC_CMD_WRITE);
            bst_ap   <= bus.addr[GSC_AP_BIT];
            bst_full <= (mode_reg[GSC_BL_LSB +: 3] == GSC_BL_FULL);
            bst_bank <= bus.ba;
            bst_mask <= COL_W'(bl_len - 9'h001);
            bst_col  <= (bus.addr[COL_W-1:0] & ~COL_W'(bl_len - 9'h001))
                      | ((bus.addr[COL_W-1:0] + 1'b1) & COL_W'(bl_len - 9'h001));
            bst_left <= bl_len - 9'h001;
        end
        else if (stop)
            bst_on <= 1'b0;
        else if (bst_on && bus.cke)
        begin
            bst_col <= (bst_col & ~bst_mask) | ((bst_col + 1'b1) & bst_mask);
            if (!bst_full)
            begin
                bst_left <= bst_left - 9'h001;
                if (bst_left == 9'h001)
                    bst_on <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // array write
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (acc_en && acc_wr && !acc_blk)
        begin
            for (int l = 0; l < GSC_LANES; l++)
                if (!bus.byte_lane_masks[l])
                    mem[{acc_bank, open_row[acc_bank], acc_col}][l*8 +: 8] <= bus.data_lines[l*8 +: 8];
        end
        else if (acc_en && acc_blk)
        begin
            for (int c = 0; c < GSC_BLK_COLS; c++)
                for (int l = 0; l < GSC_LANES; l++)
                    // data lines act as column enables here
                    if (bus.data_lines[c] && !bus.byte_lane_masks[l])
                        mem[{acc_bank, open_row[acc_bank], acc_col[COL_W-1:3], 3'(c)}][l*8 +: 8]
                            <= color[l*8 +: 8];
        end
    end

    // ---------------------------------------------------------------
    // read pipeline: mask sampled with the access, applied at output
    // ---------------------------------------------------------------
    logic [GSC_DATA_W-1:0] rd_data;
    logic                  rd_vld;
    logic [GSC_LANES-1:0]  rd_mask;

    always_ff @(posedge clk)
    begin
        rd_data <= mem[{acc_bank, open_row[acc_bank], acc_col}];
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_vld         <= 1'b0;
            rd_mask        <= '0;
            bus.dev_dq_out <= '0;
            bus.dev_dq_oe  <= '0;
        end
        else
        begin
            rd_vld         <= acc_en && !acc_wr;
            rd_mask        <= bus.byte_lane_masks;
            bus.dev_dq_out <= rd_data;
            for (int l = 0; l < GSC_LANES; l++)
                bus.dev_dq_oe[l] <= rd_vld && !rd_mask[l];
        end
    end
endmodule

`default_nettype wire

// [hw/gsc_pkg.sv]
// gsc_pkg: shared constants of the graphics sdram command link.
// assumes both ends are compiled against this package.
`default_nettype none

package gsc_pkg;
    // ---------------------------------------------------------------
    // geometry
    // ---------------------------------------------------------------
    localparam int GSC_ROW_W  = 9;
    localparam int GSC_COL_W  = 8;
    localparam int GSC_DATA_W = 32;
    localparam int GSC_LANES  = 4;
    localparam int GSC_BANKS  = 2;
    localparam int GSC_BLK_COLS = 8;
    localparam int GSC_AP_BIT = 8;
    // ---------------------------------------------------------------
    // command codes {ras_n, cas_n, we_n, special_function_select}
    // ---------------------------------------------------------------
    localparam logic [3:0] GSC_CMD_LOAD_MODE = 4'h0;
    localparam logic [3:0] GSC_CMD_LOAD_SPM  = 4'h1;
    localparam logic [3:0] GSC_CMD_REFRESH   = 4'h2;
    localparam logic [3:0] GSC_CMD_PRECHARGE = 4'h4;
    localparam logic [3:0] GSC_CMD_ACTIVE    = 4'h6;
    localparam logic [3:0] GSC_CMD_WRITE     = 4'h8;
    localparam logic [3:0] GSC_CMD_BLOCK_WR  = 4'h9;
    localparam logic [3:0] GSC_CMD_READ      = 4'hA;
    localparam logic [3:0] GSC_CMD_BURST_END = 4'hC;
    localparam logic [3:0] GSC_CMD_NOP       = 4'hE;
    // ---------------------------------------------------------------
    // mode registers
    // ---------------------------------------------------------------
    localparam logic [9:0] GSC_MODE_RESET  = 10'h000;
    localparam int         GSC_BL_LSB      = 0;
    localparam logic [2:0] GSC_BL_FULL     = 3'h7;
    localparam int         GSC_SPM_COLOR_BIT = 6;
    localparam int         GSC_READ_LAT    = 2;
    // ---------------------------------------------------------------
    // controller register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] GSC_REG_CMD    = 8'h00;
    localparam logic [7:0] GSC_REG_ADDR   = 8'h04;
    localparam logic [7:0] GSC_REG_WDATA  = 8'h08;
    localparam logic [7:0] GSC_REG_CTRL   = 8'h0C;
    localparam logic [7:0] GSC_REG_RDATA  = 8'h10;
    localparam logic [7:0] GSC_REG_STATUS = 8'h14;
    localparam int GSC_CMD_DRIVE_BIT = 8;
    localparam int GSC_CTRL_CKE_BIT  = 4;
    localparam int GSC_ST_REFUSE_BIT = 2;
    localparam int GSC_ST_RDNEW_BIT  = 3;
    localparam logic [4:0] GSC_CTRL_RESET = 5'h10;

    typedef enum logic [2:0]
    {
        GSC_ST_RUN  = 3'h1,
        GSC_ST_PDN  = 3'h2,
        GSC_ST_SREF = 3'h4
    } gsc_state_t;
endpackage

`default_nettype wire

// [testbench/gsc_link_monitor.sv]
// gsc_link_monitor: concurrent checks on the command link.
// assumes one clk; fed from gsc_if pins and memory status.
`default_nettype none
module gsc_link_monitor
    import gsc_pkg::*;
(
    // clock and reset
    input wire logic                 clk,
    input wire logic                 sys_rst,
    // link pins
    input wire logic                 cke,
    input wire logic                 cs_n,
    input wire logic                 ras_n,
    input wire logic                 cas_n,
    input wire logic                 we_n,
    input wire logic                 special_function_select,
    input wire logic                 ba,
    input wire logic [GSC_ROW_W-1:0] addr,
    input wire logic [GSC_LANES-1:0] byte_lane_masks,
    input wire logic [GSC_LANES-1:0] dev_dq_oe,
    // memory status
    input wire logic                 power_down,
    input wire logic                 self_refresh,
    input wire logic [1:0]           bank_open,
    input wire logic [9:0]           mode_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cmd;
    logic       take;
    assign cmd = {ras_n, cas_n, we_n, special_function_select};
    // commands count only while running
    assign take = !cs_n && cke && !power_down && !self_refresh;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_mode_load: assert property (
        take && cmd == GSC_CMD_LOAD_MODE |=> mode_reg == {$past(ba), $past(addr)})
        else $error("mode register not loaded");
    a_active_opens: assert property (
        take && cmd == GSC_CMD_ACTIVE |=> bank_open[$past(ba)])
        else $error("active left bank closed");
    a_prech_all: assert property (
        take && cmd == GSC_CMD_PRECHARGE && addr[8] |=> bank_open == 2'h0)
        else $error("precharge all left a bank open");
    a_prech_bank: assert property (
        take && cmd == GSC_CMD_PRECHARGE && !addr[8] |=> !bank_open[$past(ba)])
        else $error("precharge left selected bank open");
    a_cs_ignored: assert property (cs_n |=> $stable(mode_reg))
        else $error("command taken with select high");
    a_read_mask: assert property (
        |dev_dq_oe |-> (dev_dq_oe & $past(byte_lane_masks, 2)) == 4'h0)
        else $error("masked lane driven");
    a_pdn_entry: assert property ($rose(power_down) |-> !$past(cke) && $past(bank_open) == 2'h0)
        else $error("power-down entered while active");
    a_pdn_exit: assert property (power_down && cke |=> !power_down)
        else $error("power-down not left");
    c_read: cover property (take && cmd == GSC_CMD_READ);
    c_mask_wr: cover property (take && cmd == GSC_CMD_WRITE && byte_lane_masks != 4'h0);
    c_pdn: cover property ($rose(power_down));
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// tb_top: controller and memory ends joined, driven by register port.
// assumes gsc_pkg, gsc_if and both ends are compiled first.
`default_nettype none
module tb_top
    import gsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        power_down;
    logic        self_refresh;
    logic [1:0]  bank_open;
    logic [9:0]  mode_reg;
    logic [9:0]  special_mode_reg;
    logic [31:0] exp_q[$];
    logic        rd_seen = 1'b0;
    logic [8:0]  row;
    logic [7:0]  col;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] e;
    int          n_fail = 0;
    int          cmp_count = 0;
    always #5 clk = ~clk;
    gsc_if i_gsc_if (.clk(clk));
    gsc_ctrl_end i_gsc_ctrl_end (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(i_gsc_if.ctrl));
    gsc_mem_end i_gsc_mem_end (.clk(clk), .sys_rst(sys_rst), .bus(i_gsc_if.mem), .power_down(power_down),
        .self_refresh(self_refresh), .bank_open(bank_open), .mode_reg(mode_reg),
        .special_mode_reg(special_mode_reg));
    gsc_link_monitor i_gsc_link_monitor (.clk(clk), .sys_rst(sys_rst), .cke(i_gsc_if.cke),
        .cs_n(i_gsc_if.cs_n), .ras_n(i_gsc_if.ras_n), .cas_n(i_gsc_if.cas_n), .we_n(i_gsc_if.we_n),
        .special_function_select(i_gsc_if.special_function_select), .ba(i_gsc_if.ba),
        .addr(i_gsc_if.addr), .byte_lane_masks(i_gsc_if.byte_lane_masks), .dev_dq_oe(i_gsc_if.dev_dq_oe),
        .power_down(power_down), .self_refresh(self_refresh), .bank_open(bank_open), .mode_reg(mode_reg));
    task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, ex, got);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // every call sets both strobes, so no strobe is assigned twice per step
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        exp_q.push_back(ex);
        bus(1'b0, 1'b1, a, 32'h0);
    endtask
    task automatic cmd(input logic d, input logic [3:0] c, input logic b, input logic [8:0] ad);
        bus(1'b1, 1'b0, GSC_REG_ADDR, {22'h0, b, ad});
        bus(1'b1, 1'b0, GSC_REG_CMD, {23'h0, d, 4'h0, c});
    endtask
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0);
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rd_seen)
            chk("read data", exp_q.pop_front(), reg_rdata);
        rd_seen <= reg_rd;
    end
    initial
    begin
        repeat (2000) @(posedge clk);
        n_fail++;
        results();
    end
    // ---------------------------------------------------------------
    // stimulus
    // ---------------------------------------------------------------
    initial
    begin
        void'($urandom(64));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        chk("mode reset", 32'(GSC_MODE_RESET), 32'(mode_reg));
        row = 9'($urandom);
        cmd(1'b0, GSC_CMD_LOAD_MODE, 1'b1, {row[8:3], 3'h0});
        cmd(1'b0, GSC_CMD_LOAD_SPM, 1'b1, 9'h0A5);
        idle(2);
        chk("mode", 32'({1'b1, row[8:3], 3'h0}), 32'(mode_reg));
        chk("special mode", 32'h2A5, 32'(special_mode_reg));
        cmd(1'b0, GSC_CMD_ACTIVE, 1'b0, row);
        idle(2);
        chk("banks", 32'h1, 32'(bank_open));
        for (int k = 0; k < GSC_LANES; k++)
        begin
            w0 = $urandom;
            w1 = $urandom;
            col = 8'($urandom);
            bus(1'b1, 1'b0, GSC_REG_WDATA, w0);
            cmd(1'b1, GSC_CMD_WRITE, 1'b0, {1'b0, col});
            bus(1'b1, 1'b0, GSC_REG_CTRL, 32'h10 | (32'h1 << k));
            bus(1'b1, 1'b0, GSC_REG_WDATA, w1);
            cmd(1'b1, GSC_CMD_WRITE, 1'b0, {1'b0, col});
            bus(1'b1, 1'b0, GSC_REG_CTRL, 32'h10 | (32'h1 << ((k + 1) % 4)));
            cmd(1'b0, GSC_CMD_READ, 1'b0, {1'b0, col});
            bus(1'b1, 1'b0, GSC_REG_CTRL, 32'h10);
            idle(5);
            e = w1;
            e[k*8 +: 8] = w0[k*8 +: 8];
            e[((k + 1) % 4)*8 +: 8] = 8'h00;
            rd(GSC_REG_RDATA, e);
        end
        cmd(1'b0, GSC_CMD_READ, 1'b1, 9'h0);
        idle(1);
        rd(GSC_REG_STATUS, 32'h5);
        bus(1'b1, 1'b0, GSC_REG_STATUS, 32'h4);
        cmd(1'b0, GSC_CMD_ACTIVE, 1'b1, row);
        idle(2);
        chk("banks", 32'h3, 32'(bank_open));
        cmd(1'b0, GSC_CMD_PRECHARGE, 1'b1, 9'h0);
        idle(2);
        chk("banks", 32'h1, 32'(bank_open));
        cmd(1'b0, GSC_CMD_PRECHARGE, 1'b0, 9'h100);
        idle(2);
        chk("banks", 32'h0, 32'(bank_open));
        bus(1'b1, 1'b0, GSC_REG_CTRL, 32'h0);
        idle(3);
        chk("power down", 32'h1, 32'({self_refresh, power_down}));
        cmd(1'b0, GSC_CMD_LOAD_MODE, 1'b0, 9'h1F8);
        idle(2);
        chk("mode", 32'({1'b1, row[8:3], 3'h0}), 32'(mode_reg));
        bus(1'b1, 1'b0, GSC_REG_CTRL, 32'h10);
        idle(3);
        chk("power down", 32'h0, 32'({self_refresh, power_down}));
        idle(2);
        results();
    end
endmodule
`default_nettype wire
